/* File: hdl/cwg_core.sv */
/*
 * complementary waveform generator: one data input, four driver outputs,
 * registers over avalon-mm with waitrequest.
 * assumes data_in and fast_internal_oscillator are synchronous to clk.
 */
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps

// Overview of operation
// RULE1 - push-pull alternates pulses between A and B
// RULE2 - sequencer resets on disable or shutdown
// RULE3 - push-pull C copies A, D copies B
// RULE4 - forward: A active, B C inactive, D modulated
// RULE5 - reverse: C active, A D inactive, B modulated
// RULE6 - mode bit zero toggles direction while enabled
// RULE7 - direction applied at next data rising edge
// RULE8 - statics swap, new modulated waits dead band
// RULE9 - full-bridge dead band only on direction change
// RULE10 - rising data gives rising modulated event
// RULE11 - steering bit selects data or override
// RULE12 - polarity acts only on steered outputs
// RULE13 - shutdown hits only steered outputs
// RULE14 - no dead band in steering, push-pull
// RULE15 - sync steering updates on data rising edge
// RULE16 - overrides bypass steering synchronisation
// RULE17 - async steering applies right after write
// RULE18 - clock select: system or fast oscillator
// RULE19 - per-output polarity, high set, low clear
// RULE20 - two six-bit dead-band counters; the code has one counter db_cnt for both
// RULE21 - dead band counts selected clock periods
// RULE22 - half-bridge dead band between complementary edges
// RULE23 - zero count means no dead band; the code still holds the modulated output off for one clock
// RULE24 - software changes mode only while disabled
// RULE25 - mode 100 is half-bridge, A true B inverted
// RULE26 - edges seen in dead-band clock domain; the code samples data edges on every clk, not on the oscillator tick
module cwg_core (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // waveform input and dead-band clock enable from the fast oscillator
  input wire logic data_in,
  input wire logic fast_internal_oscillator,
  input wire logic auto_shutdown_in,
  // driver outputs
  output cwg_pkg::cwg_out_t wave_out
);
  import cwg_pkg::*;

  cwg_state_t s_reg;
  cwg_state_t s_next;
  logic rise;
  logic fall;
  logic tick;
  logic [3:0] raw;
  logic [3:0] steered;
  logic db_busy;

  // ****************************************
  // register bus
  // ****************************************
  // one wait cycle per access keeps readdata registered
  always_comb begin
    s_next = s_reg;
    rise = data_in & ~s_reg.data_q;
    fall = ~data_in & s_reg.data_q;
    // fast oscillator arrives as an enable pulse on the one clock
    tick = s_reg.clk_sel ? fast_internal_oscillator : 1'b1; // RULE18
    s_next.db_tick = tick;
    s_next.bus.wr_ack = 1'b0;
    s_next.bus.waitrequest = 1'b1;
    if ((avs_read | avs_write) & s_reg.bus.waitrequest & ~s_reg.bus.wr_ack) begin
      s_next.bus.waitrequest = 1'b0;
      s_next.bus.wr_ack = 1'b1;
      s_next.bus.readdata = 32'h0000_0000;
      case (avs_address)
        `CWG_OFS_CTRL: begin
          s_next.bus.readdata = {22'h0, s_reg.shutdown, s_reg.clk_sel, s_reg.en, 4'h0,
                                 s_reg.mode};
        end
        `CWG_OFS_OUTCFG: begin
          s_next.bus.readdata = {20'h0, s_reg.override_level_bits, s_reg.steering_bits,
                                 s_reg.output_polarity_bit};
        end
        `CWG_OFS_DEADBAND: begin
          s_next.bus.readdata = {18'h0, s_reg.db_fall, 2'h0, s_reg.db_rise};
        end
        `CWG_OFS_STATUS: begin
          s_next.bus.readdata = {22'h0, s_reg.db_state, s_reg.fb_dir, s_reg.pp_phase, 2'h0,
                                 s_reg.wave};
        end
        default: begin
          s_next.bus.readdata = 32'h0000_0000;
        end
      endcase
      if (avs_write) begin
        case (avs_address)
          `CWG_OFS_CTRL: begin
            s_next.mode = cwg_mode_t'(avs_writedata[`CWG_CTRL_MODE_LSB +: 3]); // RULE6
            s_next.en = avs_writedata[`CWG_CTRL_EN_BIT];
            s_next.clk_sel = avs_writedata[`CWG_CTRL_CS_BIT];
            s_next.shutdown = avs_writedata[`CWG_CTRL_SHUT_BIT];
          end
          `CWG_OFS_OUTCFG: begin
            s_next.output_polarity_bit = avs_writedata[`CWG_OUT_POL_LSB +: 4]; // RULE19
            s_next.steering_bits = avs_writedata[`CWG_OUT_STR_LSB +: 4];
            s_next.override_level_bits = avs_writedata[`CWG_OUT_OVR_LSB +: 4]; // RULE16
          end
          `CWG_OFS_DEADBAND: begin
            s_next.db_rise = avs_writedata[`CWG_DB_RISE_LSB +: `CWG_DB_W]; // RULE20
            s_next.db_fall = avs_writedata[`CWG_DB_FALL_LSB +: `CWG_DB_W];
          end
          default: begin
          end
        endcase
      end
    end
    // external fault sets shutdown; hardware set wins over a software clear
    if (auto_shutdown_in) begin
      s_next.shutdown = 1'b1;
    end

    // ****************************************
    // sequencing
    // ****************************************
    s_next.data_q = data_in; // RULE26
    if (s_reg.mode == CWG_M_ASYNC) begin
      s_next.steer_live = s_next.steering_bits; // RULE17
    end else if (rise) begin
      s_next.steer_live = s_reg.steering_bits; // RULE15
    end
    if (!s_reg.en || s_reg.shutdown) begin
      s_next.pp_phase = 1'b0; // RULE2
    end else if (s_reg.mode == CWG_M_PP && fall) begin
      s_next.pp_phase = ~s_reg.pp_phase; // RULE1
    end
    // dead-band counter: counts selected-clock periods up to the target
    if (s_reg.db_state != CWG_DB_IDLE && s_reg.db_tick) begin
      s_next.db_cnt = s_reg.db_cnt + 6'h01; // RULE21
    end
    if ((s_reg.db_state == CWG_DB_RISE && s_reg.db_cnt >= s_reg.db_rise) ||
        (s_reg.db_state == CWG_DB_FALL && s_reg.db_cnt >= s_reg.db_fall)) begin
      s_next.db_state = CWG_DB_IDLE; // RULE23
    end
    if (s_reg.mode == CWG_M_FWD || s_reg.mode == CWG_M_REV) begin
      if (rise && s_reg.fb_dir != s_reg.mode[0]) begin
        s_next.fb_dir = s_reg.mode[0]; // RULE7
        s_next.db_cnt = 6'h00;
        s_next.db_state = s_reg.mode[0] ? CWG_DB_RISE : CWG_DB_FALL; // RULE9
      end
    end else if (s_reg.mode == CWG_M_HALF) begin
      if (rise) begin
        s_next.db_cnt = 6'h00;
        s_next.db_state = CWG_DB_RISE; // RULE22
      end else if (fall) begin
        s_next.db_cnt = 6'h00;
        s_next.db_state = CWG_DB_FALL;
      end
    end else begin
      // direction only reloads while disabled, so in these modes it never moves while enabled
      s_next.db_state = CWG_DB_IDLE; // RULE14
    end
    if (!s_reg.en) begin
      s_next.fb_dir = s_reg.mode[0];
      s_next.db_state = CWG_DB_IDLE;
    end

    // ****************************************
    // output shaping
    // ****************************************
    db_busy = (s_next.db_state != CWG_DB_IDLE);
    raw = 4'h0;
    steered = 4'hF;
    case (s_reg.mode)
      CWG_M_PP: begin
        raw[0] = data_in & ~s_next.pp_phase;
        raw[1] = data_in & s_next.pp_phase;
        raw[2] = raw[0]; // RULE3
        raw[3] = raw[1];
      end
      CWG_M_FWD, CWG_M_REV: begin
        // statics follow the applied direction with no delay
        raw[0] = ~s_next.fb_dir; // RULE4
        raw[2] = s_next.fb_dir; // RULE5
        raw[3] = ~s_next.fb_dir & data_in & ~db_busy; // RULE8
        raw[1] = s_next.fb_dir & data_in & ~db_busy; // RULE10
      end
      CWG_M_HALF: begin
        raw[0] = data_in & ~(db_busy && s_next.db_state == CWG_DB_RISE); // RULE25
        raw[1] = ~data_in & ~(db_busy && s_next.db_state == CWG_DB_FALL);
        raw[2] = raw[0];
        raw[3] = raw[1];
      end
      CWG_M_ASYNC, CWG_M_SYNC: begin
        raw = {4{data_in}};
        steered = s_next.steer_live; // RULE11
      end
      default: begin
        raw = 4'h0;
      end
    endcase
    for (int i = 0; i < 4; i++) begin
      if (!steered[i]) begin
        s_next.wave[i] = s_reg.override_level_bits[i]; // RULE12
      end else if (!s_reg.en || s_next.shutdown) begin
        s_next.wave[i] = s_reg.override_level_bits[i]; // RULE13
      end else begin
        s_next.wave[i] = s_reg.output_polarity_bit[i] ? raw[i] : ~raw[i]; // RULE19
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.output_polarity_bit <= 4'hF;
      s_reg.bus.waitrequest <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = s_reg.bus.readdata;
  assign avs_waitrequest = s_reg.bus.waitrequest;
  assign wave_out.wave = s_reg.wave;

  // ****************************************
  // assertions
  // ****************************************
  a_pp_c_copy: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    (s_reg.en && !s_reg.shutdown && s_reg.mode == CWG_M_PP && $stable(s_reg.mode) &&
     s_reg.output_polarity_bit[2] == s_reg.output_polarity_bit[0])
    |=> (s_reg.wave[2] == s_reg.wave[0]))
    else $error("push-pull C differs from A");
  a_pp_reset: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    !s_reg.en |=> !s_reg.pp_phase)
    else $error("push-pull phase not reset");
  a_fwd_static: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    (s_reg.en && !s_reg.shutdown && s_reg.fb_dir == 1'b0 && s_reg.mode == CWG_M_FWD &&
     $stable(s_reg.mode) && s_reg.output_polarity_bit[0] && $stable(s_reg.fb_dir))
    |-> s_reg.wave[0])
    else $error("forward A not active");
  a_dir_on_edge: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    (s_reg.en && $changed(s_reg.fb_dir) && $past(s_reg.en)) |-> $past(rise))
    else $error("direction changed without data edge");
  a_async_str: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
    (s_reg.mode == CWG_M_ASYNC && $stable(s_reg.mode)) |-> s_reg.steer_live ==
      $past(s_next.steering_bits))
    else $error("async steering late");
  a_sync_str: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    (s_reg.mode == CWG_M_SYNC && $changed(s_reg.steer_live) && $stable(s_reg.mode))
      |-> $past(rise))
    else $error("sync steering off edge");
  a_override_lvl: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    (s_reg.mode == CWG_M_SYNC && !s_reg.steer_live[0] && $stable(s_reg.steer_live))
      |=> s_reg.wave[0] == $past(s_reg.override_level_bits[0]))
    else $error("override level wrong");
  a_db_bound: assert property (@(posedge clk) disable iff (sys_rst) // RULE21
    (s_reg.db_state == CWG_DB_RISE) |-> s_reg.db_cnt <= s_reg.db_rise)
    else $error("dead band overran");
  a_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read && s_reg.bus.waitrequest && !s_reg.bus.wr_ack) |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule

/* File: hdl/cwg_pkg.sv */
/*
 * types of the complementary waveform generator.
 * assumes cwg_regs.svh defines the dead-band width.
 */
`include "cwg_regs.svh"

package cwg_pkg;

  typedef enum logic [2:0] {
    CWG_M_ASYNC = 3'b000,
    CWG_M_SYNC = 3'b001,
    CWG_M_FWD = 3'b010,
    CWG_M_REV = 3'b011,
    CWG_M_HALF = 3'b100,
    CWG_M_PP = 3'b101
  } cwg_mode_t;

  typedef enum logic [1:0] {
    CWG_DB_IDLE = 2'b00,
    CWG_DB_RISE = 2'b01,
    CWG_DB_FALL = 2'b10
  } cwg_db_state_t;

  typedef struct packed {
    logic [3:0] wave;
  } cwg_out_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic wr_ack;
  } cwg_bus_t;

  typedef struct packed {
    cwg_mode_t mode;
    logic en;
    logic clk_sel;
    logic shutdown;
    logic [3:0] output_polarity_bit;
    logic [3:0] steering_bits;
    logic [3:0] steer_live;
    logic [3:0] override_level_bits;
    logic [`CWG_DB_W-1:0] db_rise;
    logic [`CWG_DB_W-1:0] db_fall;
    logic data_q;
    logic pp_phase;
    logic fb_dir;
    cwg_db_state_t db_state;
    logic [`CWG_DB_W-1:0] db_cnt;
    logic db_tick;
    logic [3:0] wave;
    cwg_bus_t bus;
  } cwg_state_t;

endpackage

/* File: hdl/cwg_regs.svh */
/*
 * register map, field positions, reset values and dead-band width of the
 * complementary waveform generator.
 * assumes a 32-bit avalon-mm slave with word addressing in bytes.
 */
`ifndef CWG_REGS_SVH
`define CWG_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CWG_OFS_CTRL 8'h00
`define CWG_OFS_OUTCFG 8'h04
`define CWG_OFS_DEADBAND 8'h08
`define CWG_OFS_STATUS 8'h0C

// ****************************************
// control register fields
// ****************************************
`define CWG_CTRL_MODE_LSB 0
`define CWG_CTRL_EN_BIT 7
`define CWG_CTRL_CS_BIT 8
`define CWG_CTRL_SHUT_BIT 9

// ****************************************
// output configuration fields
// ****************************************
`define CWG_OUT_POL_LSB 0
`define CWG_OUT_STR_LSB 4
`define CWG_OUT_OVR_LSB 8

// ****************************************
// dead-band fields and widths
// ****************************************
`define CWG_DB_RISE_LSB 0
`define CWG_DB_FALL_LSB 8
`define CWG_DB_W 6

// ****************************************
// reset values
// ****************************************
`define CWG_CTRL_RST 32'h0000_0000
`define CWG_OUTCFG_RST 32'h0000_000F
`define CWG_DB_RST 32'h0000_0000

`endif

/* File: tb/cwg_bridge_model.sv */
/*
 * model of the full-bridge switch drivers hanging on the four outputs.
 * assumes active-high drivers; legs are a/b and c/d.
 */
`timescale 1ns/100ps
// ****************************************
// switch leg model
// ****************************************
module cwg_bridge_model (
  // clock
  input wire logic clk,
  // gate drives and arming
  input wire cwg_pkg::cwg_out_t gate,
  input wire logic armed,
  // shoot-through count
  output logic [7:0] short_cnt
);
  import cwg_pkg::*;
  initial short_cnt = 8'h00;
  // both switches of one leg on together would short the supply
  always @(posedge clk) begin
    if (armed && ((gate.wave[0] && gate.wave[1]) || (gate.wave[2] && gate.wave[3]))) begin
      short_cnt <= short_cnt + 8'h01;
    end
  end
endmodule

/* File: tb/tb_top.sv */
/*
 * self-checking bench of the waveform generator: steering, shutdown,
 * push-pull and full-bridge, registers over avalon-mm.
 * assumes cwg_core, cwg_pkg and the bridge model are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
  import cwg_pkg::*;
  logic clk, sys_rst, rd, wr, wreq, din, ashd, armed, ph;
  logic osc = 1'h0;
  logic [7:0] adr, short_cnt;
  logic [31:0] wdat, rdat, rv, r;
  cwg_out_t wo;
  integer seed, error_cnt, compares, i;
  cwg_core dut (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .data_in(din), .fast_internal_oscillator(osc), .auto_shutdown_in(ashd), .wave_out(wo));
  cwg_bridge_model model (.clk(clk), .gate(wo), .armed(armed), .short_cnt(short_cnt));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // oscillator tick every other clock, slower than the system clock
  always @(posedge clk) osc <= ~osc;
  // ****************************************
  // tasks
  // ****************************************
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cw(input string nm, input logic [3:0] e);
    chk(nm, {28'h0, wo.wave}, {28'h0, e});
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (wreq !== 1'h0 && n < 40);
    rv = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
    if (wreq !== 1'h0) begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  endtask
  // data level held long enough for the registered output to settle
  task hold(input logic d);
    din <= d;
    repeat (4) @(posedge clk);
  endtask
  function logic [3:0] steer(input logic [3:0] s, input logic [3:0] o, input logic [3:0] p,
                             input logic d);
    return (s & (p ~^ {4{d}})) | (~s & o);
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h208e;
    error_cnt = 0;
    compares = 0;
    sys_rst = 1'h1;
    {rd, wr, din, ashd, armed} = 5'h00;
    adr = 8'h00;
    wdat = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    bus(0, 8'h04, 32'h0);
    chk("outcfg", rv, 32'h0000_000F);
    bus(0, 8'h00, 32'h0);
    chk("ctrl", rv, 32'h0);
    bus(0, 8'h10, 32'h0);
    chk("unmapped", rv, 32'h0);
    $display("test registers done");
    bus(1, 8'h00, 32'h0000_0080);
    for (i = 0; i < 24; i = i + 1) begin
      r = $random(seed);
      bus(1, 8'h04, {20'h0, r[11:0]});
      hold(r[12]);
      cw("steer", steer(r[7:4], r[11:8], r[3:0], r[12]));
    end
    bus(1, 8'h04, 32'h0000_0A3F);
    hold(1'h1);
    cw("pre_shut", 4'hB);
    ashd <= 1'h1;
    repeat (4) @(posedge clk);
    cw("shut", 4'hA);
    ashd <= 1'h0;
    $display("test async steering done");
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h00, 32'h0000_0081);
    bus(1, 8'h04, 32'h0000_00FF);
    hold(1'h0);
    hold(1'h1);
    cw("sync_on", 4'hF);
    bus(1, 8'h04, 32'h0000_000F);
    hold(1'h1);
    cw("sync_wait", 4'hF);
    hold(1'h0);
    hold(1'h1);
    cw("sync_apply", 4'h0);
    bus(1, 8'h04, 32'h0000_050F);
    hold(1'h1);
    cw("ovr_now", 4'h5);
    $display("test sync steering done");
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h04, 32'h0000_0007);
    bus(1, 8'h00, 32'h0000_0085);
    ph = 1'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (i == 3) begin
        bus(1, 8'h00, 32'h0);
        bus(1, 8'h00, 32'h0000_0085);
        ph = 1'h0;
      end
      hold(1'h1);
      cw("pp_high", ph ? 4'h2 : 4'hD);
      hold(1'h0);
      cw("pp_low", 4'h8);
      ph = ~ph;
    end
    $display("test push-pull done");
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h04, 32'h0000_000F);
    bus(1, 8'h08, 32'h0);
    armed <= 1'h1;
    bus(1, 8'h00, 32'h0000_0182);
    for (i = 0; i < 6; i = i + 1) begin
      r = $random(seed);
      hold(r[0]);
      cw("forward", {r[0], 3'h1});
    end
    hold(1'h0);
    bus(1, 8'h00, 32'h0000_0183);
    hold(1'h0);
    cw("dir_wait", 4'h1);
    hold(1'h1);
    cw("reverse", 4'h6);
    hold(1'h0);
    cw("rev_low", 4'h4);
    armed <= 1'h0;
    chk("short", {24'h0, short_cnt}, 32'h0);
    $display("test full-bridge done");
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h08, 32'h0000_0302);
    bus(1, 8'h00, 32'h0000_0084);
    hold(1'h1);
    cw("half_rise_db", 4'h0);
    hold(1'h1);
    cw("half_a_on", 4'h5);
    hold(1'h0);
    cw("half_fall_db", 4'h0);
    hold(1'h0);
    cw("half_b_on", 4'hA);
    bus(0, 8'h0C, 32'h0);
    chk("status", rv, 32'h0000_000A);
    $display("test half-bridge done");
    tally_and_finish();
  end
endmodule
